// *** rtl/rxs_status_regs.sv ***
// Read-only status register bank of the receiver baseband
`include "rxs_cfg.svh"
`default_nettype none
module rxs_status_regs
    import rxs_pkg::*;
#(
    parameter int unsigned LEN_W = `RXS_LEN_W
) (
    input  wire logic                     clk_sys_i,
    input  wire logic                     rst_b_i,
    // Register port from the serial front end
    input  wire logic [`RXS_ADDR_W-1:0]   reg_addr_i,
    input  wire logic                     reg_rd_i,
    input  wire logic                     reg_wr_i,
    input  wire logic [`RXS_DATA_W-1:0]   reg_wdata_i,
    output logic      [`RXS_DATA_W-1:0]   reg_rdata_o,
    output logic                          reg_rvalid_o,
    // Peak detector and polling sequencer
    input  wire logic [`RXS_DATA_W-1:0]   peak_level_i,
    input  wire logic                     wakeup_event_i,
    input  wire logic                     self_poll_mode_i,
    input  wire logic                     cycle_end_i,
    // Interrupt events, one-cycle pulses
    input  wire logic                     end_msg_evt_a_i,
    input  wire logic                     msg_id_found_evt_a_i,
    input  wire logic                     frame_sync_evt_a_i,
    input  wire logic                     wakeup_evt_a_i,
    input  wire logic                     end_msg_evt_b_i,
    input  wire logic                     msg_id_found_evt_b_i,
    input  wire logic                     frame_sync_evt_b_i,
    input  wire logic                     wakeup_evt_b_i,
    // Payload bit counting
    input  wire logic                     payload_bit_i,
    input  wire logic                     message_start_pattern_i,
    input  wire logic                     fifo_init_i,
    output logic      [LEN_W-1:0]         payload_length_o
);
    rxs_byte_t  peak_r;
    rxs_byte_t  peak_nxt;
    rxs_byte_t  flags;
    rxs_byte_t  flag_evt;
    rxs_len_t   bit_cnt_r;
    rxs_len_t   bit_cnt_nxt;
    rxs_len_t   len_r;
    rxs_len_t   len_nxt;
    rxs_byte_t  rdata_r;
    rxs_byte_t  rdata_nxt;
    logic       rvalid_r;
    rxs_sel_e   sel;
    logic       peak_load;
    logic       flags_read;
    logic       cnt_full;
    rxs_byte_t  acc_val;

    // Decode
    assign sel = (reg_addr_i == `RXS_ADDR_PEAK)   ? RXS_SEL_PEAK  :
                 (reg_addr_i == `RXS_ADDR_FLAGS)  ? RXS_SEL_FLAGS :
                 (reg_addr_i == `RXS_ADDR_ACC)    ? RXS_SEL_ACC   :
                 (reg_addr_i == `RXS_ADDR_LEN_LO) ? RXS_SEL_LEN   :
                                                    RXS_SEL_NONE;

    // Write strobe and data are accepted on the port but steer nothing
    assign flags_read = reg_rd_i && (sel == RXS_SEL_FLAGS);

    // Wakeup peak capture
    assign peak_load = wakeup_event_i
                     | (self_poll_mode_i & cycle_end_i);
    assign peak_nxt  = peak_load ? peak_level_i : peak_r;

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            peak_r <= `RXS_PEAK_RST;
        end else begin
            peak_r <= peak_nxt;
        end
    end

    // Interrupt request flags
    assign flag_evt[`RXS_BIT_EOM_B]   = end_msg_evt_b_i;
    assign flag_evt[`RXS_BIT_MIDF_B]  = msg_id_found_evt_b_i;
    assign flag_evt[`RXS_BIT_FSYNC_B] = frame_sync_evt_b_i;
    assign flag_evt[`RXS_BIT_WU_B]    = wakeup_evt_b_i;
    assign flag_evt[`RXS_BIT_EOM_A]   = end_msg_evt_a_i;
    assign flag_evt[`RXS_BIT_MIDF_A]  = msg_id_found_evt_a_i;
    assign flag_evt[`RXS_BIT_FSYNC_A] = frame_sync_evt_a_i;
    assign flag_evt[`RXS_BIT_WU_A]    = wakeup_evt_a_i;

    for (genvar gi = 0; gi < `RXS_DATA_W; gi++) begin : g_flag
        rxs_flag_bit u_flag (
            .clk_sys_i (clk_sys_i),
            .rst_b_i   (rst_b_i),
            .set_i     (flag_evt[gi]),
            .clr_i     (flags_read),
            .flag_o    (flags[gi])
        );
    end

    // Payload bit counter; saturates so a long frame cannot wrap to a short length
    assign cnt_full    = (bit_cnt_r == `RXS_LEN_MAX);
    assign bit_cnt_nxt = fifo_init_i              ? `RXS_LEN_RST :
                         message_start_pattern_i  ? `RXS_LEN_RST :
                         (payload_bit_i && !cnt_full) ? bit_cnt_r + `RXS_LEN_ONE :
                                                    bit_cnt_r;
    // Length of the finished message is held until the next start pattern or FIFO init, which clears it
    assign len_nxt = fifo_init_i             ? `RXS_LEN_RST :
                     message_start_pattern_i ? bit_cnt_r :
                                               len_r;

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bit_cnt_r <= `RXS_LEN_RST;
            len_r     <= `RXS_LEN_RST;
        end else begin
            bit_cnt_r <= bit_cnt_nxt;
            len_r     <= len_nxt;
        end
    end

    assign payload_length_o = LEN_W'(len_r);

    // Channel/config register: only the length MSBs are live
    assign acc_val = {len_r[`RXS_LEN_MSB_HI:`RXS_LEN_MSB_LO], `RXS_ACC_PAD};

    // Read mux; unmapped addresses read as zero
    assign rdata_nxt = (sel == RXS_SEL_PEAK)  ? peak_r :
                       (sel == RXS_SEL_FLAGS) ? flags :
                       (sel == RXS_SEL_ACC)   ? acc_val :
                       (sel == RXS_SEL_LEN)   ? len_r[`RXS_LEN_LSB_HI:`RXS_LEN_LSB_LO] :
                                                `RXS_RDATA_RST;

    // Read data is the value before the clear of the same read
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_r  <= `RXS_RDATA_RST;
            rvalid_r <= 1'b0;
        end else begin
            rdata_r  <= reg_rd_i ? rdata_nxt : rdata_r;
            rvalid_r <= reg_rd_i;
        end
    end

    assign reg_rdata_o  = rdata_r;
    assign reg_rvalid_o = rvalid_r;

    // Checks
    property p_peak_wakeup_load;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        wakeup_event_i |=> (peak_r == $past(peak_level_i));
    endproperty
    a_peak_wakeup_load: assert property (p_peak_wakeup_load)
        else $error("peak level not loaded at wakeup");

    property p_peak_poll_load;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (self_poll_mode_i && cycle_end_i) |=> (peak_r == $past(peak_level_i));
    endproperty
    a_peak_poll_load: assert property (p_peak_poll_load)
        else $error("peak level not loaded at polling cycle end");

    property p_peak_hold;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (!wakeup_event_i && !(self_poll_mode_i && cycle_end_i)) |=> $stable(peak_r);
    endproperty
    a_peak_hold: assert property (p_peak_hold)
        else $error("peak level changed without a load");

    property p_peak_read_keeps;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (reg_rd_i && sel == RXS_SEL_PEAK && !peak_load)
            |=> (reg_rdata_o == peak_r) && reg_rvalid_o;
    endproperty
    a_peak_read_keeps: assert property (p_peak_read_keeps)
        else $error("peak level read changed the value");

    property p_flags_reset;
        @(posedge clk_sys_i)
        !rst_b_i |=> (flags == `RXS_FLAGS_RST) || !rst_b_i;
    endproperty
    a_flags_reset: assert property (p_flags_reset)
        else $error("flags not all ones after reset");

    property p_flag_clear_b;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (flags_read && flag_evt[`RXS_BIT_EOM_B:`RXS_BIT_WU_B] == 4'h0)
            |=> (flags[`RXS_BIT_EOM_B:`RXS_BIT_WU_B] == 4'h0)
                && (reg_rdata_o[`RXS_BIT_EOM_B:`RXS_BIT_WU_B]
                    == $past(flags[`RXS_BIT_EOM_B:`RXS_BIT_WU_B]));
    endproperty
    a_flag_clear_b: assert property (p_flag_clear_b)
        else $error("config B flags not read and cleared");

    property p_flag_clear_a;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (flags_read && flag_evt[`RXS_BIT_EOM_A:`RXS_BIT_WU_A] == 4'h0)
            |=> (flags[`RXS_BIT_EOM_A:`RXS_BIT_WU_A] == 4'h0)
                && (reg_rdata_o[`RXS_BIT_EOM_A:`RXS_BIT_WU_A]
                    == $past(flags[`RXS_BIT_EOM_A:`RXS_BIT_WU_A]));
    endproperty
    a_flag_clear_a: assert property (p_flag_clear_a)
        else $error("config A flags not read and cleared");

    property p_flag_set_wins;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (flags_read && end_msg_evt_b_i && wakeup_evt_a_i)
            |=> flags[`RXS_BIT_EOM_B] && flags[`RXS_BIT_WU_A];
    endproperty
    a_flag_set_wins: assert property (p_flag_set_wins)
        else $error("event lost against read clear");

    property p_len_latch;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (message_start_pattern_i && !fifo_init_i)
            |=> (len_r == $past(bit_cnt_r)) && (bit_cnt_r == `RXS_LEN_RST);
    endproperty
    a_len_latch: assert property (p_len_latch)
        else $error("payload length not latched at message start");

    property p_acc_layout;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (reg_rd_i && sel == RXS_SEL_ACC)
            |=> (reg_rdata_o
                 == {$past(len_r[`RXS_LEN_MSB_HI:`RXS_LEN_MSB_LO]), `RXS_ACC_PAD});
    endproperty
    a_acc_layout: assert property (p_acc_layout)
        else $error("channel register layout wrong");

    property p_len_clear;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        fifo_init_i |=> (len_r == `RXS_LEN_RST) && (bit_cnt_r == `RXS_LEN_RST);
    endproperty
    a_len_clear: assert property (p_len_clear)
        else $error("payload length not cleared at FIFO init");

    property p_cnt_step;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (payload_bit_i && !fifo_init_i && !message_start_pattern_i)
            |=> (bit_cnt_r == ($past(cnt_full) ? `RXS_LEN_MAX
                                               : $past(bit_cnt_r) + `RXS_LEN_ONE));
    endproperty
    a_cnt_step: assert property (p_cnt_step)
        else $error("bit count step or saturation wrong");

    property p_write_no_effect;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (reg_wr_i && !reg_rd_i && flag_evt == `RXS_FLAGS_CLR && !peak_load
            && !fifo_init_i && !message_start_pattern_i)
            |=> $stable(flags) && $stable(peak_r) && $stable(len_r);
    endproperty
    a_write_no_effect: assert property (p_write_no_effect)
        else $error("write altered a read-only register");

    property p_flags_read_data;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        flags_read
            |=> reg_rvalid_o && (reg_rdata_o == $past(flags));
    endproperty
    a_flags_read_data: assert property (p_flags_read_data)
        else $error("flag read did not return the flags before the clear");

    property p_flag_keep;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        !flags_read
            |=> ((flags & $past(flags)) == $past(flags));
    endproperty
    a_flag_keep: assert property (p_flag_keep)
        else $error("flag cleared without a read");

    property p_flag_set_any;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (flag_evt != `RXS_FLAGS_CLR)
            |=> ((flags & $past(flag_evt)) == $past(flag_evt));
    endproperty
    a_flag_set_any: assert property (p_flag_set_any)
        else $error("interrupt event did not set its flag");

    property p_len_hold;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (!fifo_init_i && !message_start_pattern_i)
            |=> $stable(len_r);
    endproperty
    a_len_hold: assert property (p_len_hold)
        else $error("payload length changed between message starts");

    property p_len_lo_read;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (reg_rd_i && sel == RXS_SEL_LEN)
            |=> (reg_rdata_o == $past(len_r[`RXS_LEN_LSB_HI:`RXS_LEN_LSB_LO]));
    endproperty
    a_len_lo_read: assert property (p_len_lo_read)
        else $error("payload length low byte read wrong");

    c_wakeup_load:  cover property (@(posedge clk_sys_i) disable iff (!rst_b_i)
                                    wakeup_event_i ##1 reg_rd_i && sel == RXS_SEL_PEAK);
    c_flag_clear:   cover property (@(posedge clk_sys_i) disable iff (!rst_b_i)
                                    flags_read ##1 flags == `RXS_FLAGS_CLR);
    c_set_on_read:  cover property (@(posedge clk_sys_i) disable iff (!rst_b_i)
                                    flags_read && frame_sync_evt_a_i);
    c_len_latch:    cover property (@(posedge clk_sys_i) disable iff (!rst_b_i)
                                    message_start_pattern_i && bit_cnt_r != `RXS_LEN_RST);
    c_cnt_sat:      cover property (@(posedge clk_sys_i) disable iff (!rst_b_i)
                                    cnt_full && payload_bit_i);
endmodule : rxs_status_regs
`default_nettype wire

// *** rtl/rxs_cfg.svh ***
// Address map, field positions, reset values and limits of the receiver status bank
`ifndef RXS_CFG_SVH
`define RXS_CFG_SVH

`define RXS_ADDR_W          8
`define RXS_DATA_W          8
`define RXS_LEN_W           10

`define RXS_ADDR_PEAK       8'ha7
`define RXS_ADDR_FLAGS      8'ha8
`define RXS_ADDR_ACC        8'haa
`define RXS_ADDR_LEN_LO     8'had

`define RXS_PEAK_RST        8'h00
`define RXS_FLAGS_RST       8'hff
`define RXS_FLAGS_CLR       8'h00
`define RXS_LEN_RST         10'h000
`define RXS_LEN_MAX         10'h3ff
`define RXS_LEN_ONE         10'h001
`define RXS_RDATA_RST       8'h00
`define RXS_ACC_PAD         6'h00

`define RXS_BIT_EOM_B       7
`define RXS_BIT_MIDF_B      6
`define RXS_BIT_FSYNC_B     5
`define RXS_BIT_WU_B        4
`define RXS_BIT_EOM_A       3
`define RXS_BIT_MIDF_A      2
`define RXS_BIT_FSYNC_A     1
`define RXS_BIT_WU_A        0

`define RXS_LEN_MSB_HI      9
`define RXS_LEN_MSB_LO      8
`define RXS_LEN_LSB_HI      7
`define RXS_LEN_LSB_LO      0

`endif

// *** rtl/rxs_pkg.sv ***
// Types shared by the receiver status bank
`default_nettype none
package rxs_pkg;
    typedef logic [7:0] rxs_byte_t;
    typedef logic [9:0] rxs_len_t;
    typedef enum logic [4:0] {
        RXS_SEL_NONE  = 5'b00001,
        RXS_SEL_PEAK  = 5'b00010,
        RXS_SEL_FLAGS = 5'b00100,
        RXS_SEL_ACC   = 5'b01000,
        RXS_SEL_LEN   = 5'b10000
    } rxs_sel_e;
endpackage : rxs_pkg
`default_nettype wire

// *** rtl/rxs_flag_bit.sv ***
// One read-to-clear interrupt request flag that sets to one at reset
`default_nettype none
module rxs_flag_bit (
    input  wire logic clk_sys_i,
    input  wire logic rst_b_i,
    input  wire logic set_i,
    input  wire logic clr_i,
    output logic      flag_o
);
    logic flag_r;
    logic flag_nxt;

    // Set beats clear so an event arriving during the read survives it
    assign flag_nxt = set_i | (flag_r & ~clr_i);

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            flag_r <= 1'b1;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    assign flag_o = flag_r;
endmodule : rxs_flag_bit
`default_nettype wire

// *** sim/rxs_host_model.sv ***
// Host-side model that reads the status bank over its strobe port
`include "rxs_cfg.svh"
`default_nettype none
module rxs_host_model (
    input  wire logic                   clk_sys_i,
    input  wire logic [`RXS_DATA_W-1:0] reg_rdata_i,
    input  wire logic                   reg_rvalid_i,
    output logic      [`RXS_ADDR_W-1:0] reg_addr_o,
    output logic                        reg_rd_o,
    output logic                        reg_wr_o,
    output logic      [`RXS_DATA_W-1:0] reg_wdata_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        reg_addr_o  = 8'h00;
        reg_rd_o    = 1'b0;
        reg_wr_o    = 1'b0;
        reg_wdata_o = 8'h00;
    end
    // Idle address shows the inverse of the last one so a stale decode cannot pass
    task automatic rd(input logic [7:0] addr, output logic [7:0] data, output logic ok);
        @(negedge clk_sys_i);
        reg_addr_o = addr;
        reg_rd_o   = 1'b1;
        @(negedge clk_sys_i);
        reg_rd_o   = 1'b0;
        reg_addr_o = ~addr;
        ok         = reg_rvalid_i;
        data       = reg_rdata_i;
    endtask : rd
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clk_sys_i);
        reg_addr_o  = addr;
        reg_wdata_o = data;
        reg_wr_o    = 1'b1;
        @(negedge clk_sys_i);
        reg_wr_o    = 1'b0;
        reg_addr_o  = ~addr;
        reg_wdata_o = ~data;
    endtask : wr
endmodule : rxs_host_model
`default_nettype wire

// *** sim/rxs_status_regs_tb.sv ***
// Self-checking bench for the receiver status bank
`include "rxs_cfg.svh"
`default_nettype none
module rxs_status_regs_tb;
    import rxs_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk_sys = 1'b0;
    logic       rst_b = 1'b0;
    logic [7:0] addr, wdata, rdata, peak = 8'h00, evt = 8'h00;
    logic       rd, wr, rvalid, wake = 1'b0, poll = 1'b0, cyc_end = 1'b0;
    logic       pbit = 1'b0, start = 1'b0, init = 1'b0;
    rxs_len_t   plen;
    int         err_total = 0;
    int         total_checks = 0;

    always #25 clk_sys = ~clk_sys;

    rxs_status_regs rxs_status_regs_inst (
        .clk_sys_i(clk_sys), .rst_b_i(rst_b), .reg_addr_i(addr), .reg_rd_i(rd),
        .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
        .peak_level_i(peak), .wakeup_event_i(wake), .self_poll_mode_i(poll),
        .cycle_end_i(cyc_end), .end_msg_evt_a_i(evt[3]), .msg_id_found_evt_a_i(evt[2]),
        .frame_sync_evt_a_i(evt[1]), .wakeup_evt_a_i(evt[0]), .end_msg_evt_b_i(evt[7]),
        .msg_id_found_evt_b_i(evt[6]), .frame_sync_evt_b_i(evt[5]),
        .wakeup_evt_b_i(evt[4]), .payload_bit_i(pbit), .message_start_pattern_i(start),
        .fifo_init_i(init), .payload_length_o(plen)
    );
    rxs_host_model rxs_host_model_inst (
        .clk_sys_i(clk_sys), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid),
        .reg_addr_o(addr), .reg_rd_o(rd), .reg_wr_o(wr), .reg_wdata_o(wdata)
    );

    task automatic complete_run();
        if (err_total == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic rdchk(input string nm, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic       ok;
        rxs_host_model_inst.rd(a, d, ok);
        chk({nm, " rvalid"}, {15'h0, ok}, 16'h0001);
        chk(nm, {8'h00, d}, {8'h00, exp});
        // Valid is a single-cycle pulse while the data must stand until the next read
        @(negedge clk_sys);
        chk({nm, " rvalid drop"}, {15'h0, rvalid}, 16'h0000);
        chk({nm, " hold"}, {8'h00, rdata}, {8'h00, exp});
    endtask : rdchk

    // One pulse of a strobe that the bench drives, one cycle wide
    task automatic pulse(ref logic s);
        @(negedge clk_sys);
        s = 1'b1;
        @(negedge clk_sys);
        s = 1'b0;
    endtask : pulse

    task automatic t_reset_values();
        rdchk("peak rst", `RXS_ADDR_PEAK, 8'h00);
        rdchk("flags rst", `RXS_ADDR_FLAGS, 8'hff);
        rdchk("flags cleared", `RXS_ADDR_FLAGS, 8'h00);
        rdchk("acc rst", `RXS_ADDR_ACC, 8'h00);
        rdchk("len lo rst", `RXS_ADDR_LEN_LO, 8'h00);
        rdchk("unmapped", 8'ha9, 8'h00);
    endtask : t_reset_values

    task automatic t_flag_bits();
        for (int i = 0; i < 8; i++) begin
            @(negedge clk_sys);
            evt = 8'h01 << i;
            @(negedge clk_sys);
            evt = 8'h00;
            rdchk("flag set", `RXS_ADDR_FLAGS, 8'h01 << i);
            rdchk("flag clear", `RXS_ADDR_FLAGS, 8'h00);
        end
    endtask : t_flag_bits

    task automatic t_set_during_clear();
        fork
            rdchk("read at set", `RXS_ADDR_FLAGS, 8'h00);
            begin
                @(negedge clk_sys);
                evt = 8'h81;
                @(negedge clk_sys);
                evt = 8'h00;
            end
        join
        rdchk("set survives clear", `RXS_ADDR_FLAGS, 8'h81);
    endtask : t_set_during_clear

    task automatic t_peak();
        peak = 8'h5a;
        pulse(wake);
        peak = 8'h33;
        rdchk("peak wakeup", `RXS_ADDR_PEAK, 8'h5a);
        rdchk("peak no clear", `RXS_ADDR_PEAK, 8'h5a);
        pulse(cyc_end);
        rdchk("peak no poll", `RXS_ADDR_PEAK, 8'h5a);
        poll = 1'b1;
        pulse(cyc_end);
        poll = 1'b0;
        peak = 8'hc4;
        rdchk("peak poll end", `RXS_ADDR_PEAK, 8'h33);
        rxs_host_model_inst.wr(`RXS_ADDR_PEAK, 8'h11);
        rxs_host_model_inst.wr(`RXS_ADDR_FLAGS, 8'hff);
        rdchk("peak write", `RXS_ADDR_PEAK, 8'h33);
        rdchk("flags write", `RXS_ADDR_FLAGS, 8'h00);
    endtask : t_peak

    // Sends n payload bits, then a start pattern, and checks the latched length
    task automatic t_len(input int n, input rxs_len_t exp);
        @(negedge clk_sys);
        pbit = 1'b1;
        repeat (n) @(negedge clk_sys);
        pbit = 1'b0;
        pulse(start);
        chk("len port", {6'h00, plen}, {6'h00, exp});
        rdchk("len hi", `RXS_ADDR_ACC, {exp[9:8], 6'h00});
        rdchk("len lo", `RXS_ADDR_LEN_LO, exp[7:0]);
    endtask : t_len

    task automatic t_payload();
        pulse(init);
        t_len(5, 10'h005);
        t_len(707, 10'h2c3);
        t_len(1030, 10'h3ff);
        pulse(init);
        chk("len init", {6'h00, plen}, 16'h0000);
        rdchk("len lo init", `RXS_ADDR_LEN_LO, 8'h00);
    endtask : t_payload

    // Reset in mid-run must clear the held peak and raise every flag again
    task automatic t_reset_mid();
        @(negedge clk_sys);
        rst_b = 1'b0;
        repeat (2) @(negedge clk_sys);
        rst_b = 1'b1;
        rdchk("peak mid rst", `RXS_ADDR_PEAK, 8'h00);
        rdchk("flags mid rst", `RXS_ADDR_FLAGS, 8'hff);
        rdchk("flags mid clear", `RXS_ADDR_FLAGS, 8'h00);
    endtask : t_reset_mid

    initial begin
        #(50 * 20000);
        err_total++;
        complete_run();
    end

    initial begin
        repeat (2) @(negedge clk_sys);
        rst_b = 1'b1;
        t_reset_values();
        t_flag_bits();
        t_set_during_clear();
        t_peak();
        t_payload();
        t_reset_mid();
        complete_run();
    end
endmodule : rxs_status_regs_tb
`default_nettype wire
